// [hdl/host_port_params.svh]
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 100 MHz aclk, 32-bit AXI4-Lite data
// Notes: Bus pins are carried active high inside the block
`ifndef HOST_PORT_PARAMS_SVH
`define HOST_PORT_PARAMS_SVH
`define AXI_ADDR_W 8
`define REG_CONTROL 8'h00
`define REG_STATUS 8'h04
`define REG_COMMAND 8'h08
`define REG_BOARD_STATUS 8'h0C
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define CTL_CMD_CLEAR 0
`define CTL_BUSY_SET 1
`define CTL_BUSY_CLEAR 2
`define CTL_LED_OFF 3
`define CTL_LED_ON 4
`define CTL_BASE_SET 5
`define CTL_BASE_CLEAR 6
`define CTL_ARBITRATE 7
`define CTL_RELEASE 8
`define CTL_FAULT_CLEAR 9
`define ST_COMMAND 0
`define ST_BUSY 1
`define ST_SELECTED 2
`define ST_GRANT_ACK 3
`define ST_FAULT 4
`define ST_LED 5
`define ST_BASE_REQ 6
`define ST_REQUESTING 7
`define ST_ARBITRATING 8
`define BOARD_LSB 20
`define BOARD_MSB 23
`define SLAVE_REG_LSB 1
`define SLAVE_REG_MSB 2
`define SLAVE_CMD 2'h0
`define SLAVE_STATUS 2'h1
`define BOARD_STATUS_RESET 16'h0000
`define LED_RESET 1'b1
`define ACLK_HZ 100000000
`define ACLK_PERIOD_NS 10
`define SYSTEM_CLOCK_HZ 8000000
`define BAUD_REF_HZ 3686400
`define ARB_SETTLE_NS 200
`define ARB_SETTLE_CYCLES ((`ARB_SETTLE_NS + `ACLK_PERIOD_NS - 1) / `ACLK_PERIOD_NS)
`endif

// [hdl/host_port_pkg.sv]
// Purpose: Types shared by the host port
// Assumes: Nothing
// Notes: Pin groups travel as packed structs
package host_port_pkg;
    typedef struct packed {
        logic [23:1] address;
        logic address_valid_strobe;
        logic host_writes;
        logic [15:0] data;
        logic bus_grant_line;
        logic bus_fault_line;
        logic bus_reset;
        logic [2:0] priority_lines;
    } sysbus_in_t;
    typedef struct packed {
        logic [15:0] data;
        logic data_oe;
        logic transfer_acknowledge_line;
        logic bus_request_line;
        logic grant_acknowledge_line;
        logic [2:0] priority_out;
        logic [2:0] priority_oe;
        logic busy;
        logic command_block_base_request;
    } sysbus_out_t;
    typedef enum logic [2:0] {ARB_IDLE, ARB_STAGE1, ARB_STAGE2, ARB_REQUEST, ARB_OWNED} arb_state_t;
    typedef enum logic {SLV_IDLE, SLV_ACK} slave_state_t;
endpackage

// [hdl/pin_sync.sv]
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Inputs are asynchronous to aclk
// Notes: Output moves only when stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out
);
    logic [WIDTH-1:0] s1, s2, s3, next_out;

    always_comb begin
        next_out = (s2 & s3) | (pin_out & (s2 | s3));
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            pin_out <= '0;
        end else begin
            s1 <= pin_in;
            s2 <= s1;
            s3 <= s2;
            pin_out <= next_out;
        end
    end
endmodule
`default_nettype wire

// [hdl/clock_gen.sv]
// Purpose: System, local processor and baud reference clocks
// Assumes: aclk at `ACLK_HZ
// Notes: Phase accumulators; edges jitter by one aclk period
`timescale 1ns/10ps
`default_nettype none
`include "host_port_params.svh"
module clock_gen (
    input wire logic aclk,
    input wire logic aresetn,
    output logic system_clock,
    output logic local_cpu_clock,
    output logic baud_reference_clock
);
    localparam logic [31:0] SYS_INC = 32'((64'(`SYSTEM_CLOCK_HZ) << 32) / 64'(`ACLK_HZ));
    localparam logic [31:0] BAUD_INC = 32'((64'(`BAUD_REF_HZ) << 32) / 64'(`ACLK_HZ));
    logic [31:0] sys_acc, baud_acc, next_sys_acc, next_baud_acc;
    logic next_local;

    always_comb begin
        next_sys_acc = sys_acc + SYS_INC;
        next_baud_acc = baud_acc + BAUD_INC;
        next_local = local_cpu_clock;
        if (next_sys_acc[31] && !sys_acc[31]) begin
            next_local = !local_cpu_clock;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sys_acc <= '0;
            baud_acc <= '0;
            system_clock <= 1'b0;
            local_cpu_clock <= 1'b0;
            baud_reference_clock <= 1'b0;
        end else begin
            sys_acc <= next_sys_acc;
            baud_acc <= next_baud_acc;
            system_clock <= next_sys_acc[31];
            local_cpu_clock <= next_local;
            baud_reference_clock <= next_baud_acc[31];
        end
    end
endmodule
`default_nettype wire

// [hdl/host_bus_slave_command_port.sv]
// Purpose: Host bus slave port, command latch, flags and bus mastership
// Assumes: Local processor reaches the block over AXI4-Lite
// Notes: System bus pins are active high here; pads invert
`timescale 1ns/10ps
`default_nettype none
`include "host_port_params.svh"
module host_bus_slave_command_port (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [`AXI_ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [`AXI_ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire host_port_pkg::sysbus_in_t sysbus_pins,
    input wire logic [3:0] board_address_switch,
    input wire logic [2:0] first_stage_level,
    input wire logic [2:0] second_stage_level,
    output host_port_pkg::sysbus_out_t sysbus_drive,
    output logic led_on,
    output wire logic system_clock,
    output wire logic local_cpu_clock,
    output wire logic baud_reference_clock
);
    import host_port_pkg::*;

    // ***************************************************
    // Pin synchronisation and clocks
    // ***************************************************
    localparam int SYNC_W = $bits(sysbus_in_t) + 10;
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(`ARB_SETTLE_CYCLES - 1);

    logic [SYNC_W-1:0] pins_raw;
    logic [SYNC_W-1:0] pins_sync;
    sysbus_in_t bus;
    logic [2:0] first_lvl;
    logic [2:0] second_lvl;
    logic [3:0] board_sw;

    assign pins_raw = {first_stage_level, second_stage_level, board_address_switch, sysbus_pins};
    assign {first_lvl, second_lvl, board_sw, bus} = pins_sync;

    pin_sync #(.WIDTH(SYNC_W)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_in(pins_raw),
        .pin_out(pins_sync)
    );

    clock_gen u_clk (
        .aclk(aclk),
        .aresetn(aresetn),
        .system_clock(system_clock),
        .local_cpu_clock(local_cpu_clock),
        .baud_reference_clock(baud_reference_clock)
    );

    function automatic logic [31:0] strobe_mask(input logic [3:0] strb);
        strobe_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    endfunction

    function automatic logic [2:0] level_won(input logic [2:0] lines, input logic [2:0] lvl);
        level_won = {2'b00, (lines == lvl)};
    endfunction

    // ***************************************************
    // AXI4-Lite slave
    // ***************************************************
    logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;
    logic [`AXI_ADDR_W-1:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data, w_mask, next_w_mask;
    logic wr_fire;
    logic [31:0] rd_word;
    logic rd_ok;
    logic [31:0] status_word;
    logic command_pending, busy, base_request, fault, board_selected;
    logic [15:0] command_word, board_status;
    arb_state_t arb_state;

    always_comb begin
        status_word = '0;
        status_word[`ST_COMMAND] = command_pending;
        status_word[`ST_BUSY] = busy;
        status_word[`ST_SELECTED] = board_selected;
        status_word[`ST_GRANT_ACK] = (arb_state == ARB_OWNED);
        status_word[`ST_FAULT] = fault;
        status_word[`ST_LED] = led_on;
        status_word[`ST_BASE_REQ] = base_request;
        status_word[`ST_REQUESTING] = (arb_state == ARB_REQUEST);
        status_word[`ST_ARBITRATING] = (arb_state == ARB_STAGE1) || (arb_state == ARB_STAGE2);
        rd_ok = 1'b1;
        case (araddr)
            `REG_CONTROL: rd_word = '0;
            `REG_STATUS: rd_word = status_word;
            `REG_COMMAND: rd_word = {16'h0000, command_word};
            `REG_BOARD_STATUS: rd_word = {16'h0000, board_status};
            default: begin
                rd_word = '0;
                rd_ok = 1'b0;
            end
        endcase
    end

    always_comb begin
        next_awready = awready;
        next_wready = wready;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_arready = arready;
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_mask = w_mask;
        wr_fire = 1'b0;
        if (awvalid && awready) begin
            next_awready = 1'b0;
            next_aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            next_wready = 1'b0;
            next_w_data = wdata;
            next_w_mask = strobe_mask(wstrb);
        end
        if (!awready && !wready && !bvalid) begin
            wr_fire = 1'b1;
            next_bvalid = 1'b1;
            case (aw_addr)
                `REG_CONTROL, `REG_STATUS, `REG_COMMAND, `REG_BOARD_STATUS: next_bresp = `RESP_OKAY;
                default: next_bresp = `RESP_SLVERR;
            endcase
        end
        if (bvalid && bready) begin
            next_bvalid = 1'b0;
            next_awready = 1'b1;
            next_wready = 1'b1;
        end
        if (arvalid && arready) begin
            next_arready = 1'b0;
            next_rvalid = 1'b1;
            next_rdata = rd_word;
            next_rresp = rd_ok ? `RESP_OKAY : `RESP_SLVERR;
        end
        if (rvalid && rready) begin
            next_rvalid = 1'b0;
            next_arready = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= `RESP_OKAY;
            aw_addr <= '0;
            w_data <= '0;
            w_mask <= '0;
        end else begin
            awready <= next_awready;
            wready <= next_wready;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            arready <= next_arready;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_mask <= next_w_mask;
        end
    end

    // ***************************************************
    // Host slave access
    // ***************************************************
    slave_state_t slave_state, next_slave_state;
    logic next_board_selected, match, cmd_latch;
    logic xfer_ack, next_xfer_ack, data_oe, next_data_oe;
    logic [15:0] data_out, next_data_out;
    logic [1:0] slave_reg;

    always_comb begin
        match = bus.address_valid_strobe && (bus.address[`BOARD_MSB:`BOARD_LSB] == board_sw);
        slave_reg = bus.address[`SLAVE_REG_MSB:`SLAVE_REG_LSB];
        next_board_selected = match;
        next_slave_state = slave_state;
        next_xfer_ack = xfer_ack;
        next_data_oe = data_oe;
        next_data_out = data_out;
        cmd_latch = 1'b0;
        case (slave_state)
            SLV_IDLE: begin
                if (match && bus.host_writes && slave_reg == `SLAVE_CMD) begin
                    cmd_latch = 1'b1;
                    next_xfer_ack = 1'b1;
                    next_slave_state = SLV_ACK;
                end else if (match && !bus.host_writes && slave_reg == `SLAVE_STATUS) begin
                    next_data_out = board_status;
                    next_data_oe = 1'b1;
                    next_xfer_ack = 1'b1;
                    next_slave_state = SLV_ACK;
                end
            end
            SLV_ACK: begin
                if (!bus.address_valid_strobe) begin
                    next_xfer_ack = 1'b0;
                    next_data_oe = 1'b0;
                    next_slave_state = SLV_IDLE;
                end
            end
            default: begin
                next_xfer_ack = 1'b0;
                next_data_oe = 1'b0;
                next_slave_state = SLV_IDLE;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            slave_state <= SLV_IDLE;
            board_selected <= 1'b0;
            xfer_ack <= 1'b0;
            data_oe <= 1'b0;
            data_out <= '0;
        end else begin
            slave_state <= next_slave_state;
            board_selected <= next_board_selected;
            xfer_ack <= next_xfer_ack;
            data_oe <= next_data_oe;
            data_out <= next_data_out;
        end
    end

    // ***************************************************
    // Flags and local registers
    // ***************************************************
    logic [31:0] ctl;
    logic next_command_pending, next_busy, next_base_request, next_fault, next_led, bus_active;
    logic [15:0] next_command_word, next_board_status;

    always_comb begin
        ctl = (wr_fire && aw_addr == `REG_CONTROL) ? (w_data & w_mask) : '0;
        bus_active = (arb_state == ARB_REQUEST) || (arb_state == ARB_OWNED) || (slave_state == SLV_ACK);
        next_command_pending = command_pending;
        next_command_word = command_word;
        next_busy = busy;
        next_base_request = base_request;
        next_fault = fault;
        next_led = led_on;
        next_board_status = board_status;
        if (ctl[`CTL_CMD_CLEAR]) begin
            next_command_pending = 1'b0;
        end
        if (cmd_latch) begin
            next_command_pending = 1'b1;
            next_command_word = bus.data;
        end
        if (ctl[`CTL_BUSY_CLEAR]) begin
            next_busy = 1'b0;
        end
        if (ctl[`CTL_BUSY_SET]) begin
            next_busy = 1'b1;
        end
        if (ctl[`CTL_BASE_CLEAR]) begin
            next_base_request = 1'b0;
        end
        if (ctl[`CTL_BASE_SET]) begin
            next_base_request = 1'b1;
        end
        if (ctl[`CTL_FAULT_CLEAR]) begin
            next_fault = 1'b0;
        end
        if (bus.bus_fault_line && bus_active) begin
            next_fault = 1'b1;
        end
        if (ctl[`CTL_LED_ON]) begin
            next_led = 1'b1;
        end
        if (ctl[`CTL_LED_OFF]) begin
            next_led = 1'b0;
        end
        if (wr_fire && aw_addr == `REG_BOARD_STATUS) begin
            next_board_status = (board_status & ~w_mask[15:0]) | (w_data[15:0] & w_mask[15:0]);
        end
        if (bus.bus_reset) begin
            next_command_pending = 1'b0;
            next_busy = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            command_pending <= 1'b0;
            command_word <= '0;
            busy <= 1'b0;
            base_request <= 1'b0;
            fault <= 1'b0;
            led_on <= `LED_RESET;
            board_status <= `BOARD_STATUS_RESET;
        end else begin
            command_pending <= next_command_pending;
            command_word <= next_command_word;
            busy <= next_busy;
            base_request <= next_base_request;
            fault <= next_fault;
            led_on <= next_led;
            board_status <= next_board_status;
        end
    end

    // ***************************************************
    // Priority arbitration and mastership
    // ***************************************************
    arb_state_t next_arb_state;
    logic [CNT_W-1:0] arb_cnt, next_arb_cnt;
    logic [2:0] drive_level;

    always_comb begin
        next_arb_state = arb_state;
        next_arb_cnt = '0;
        drive_level = '0;
        case (arb_state)
            ARB_IDLE: begin
                if (ctl[`CTL_ARBITRATE]) begin
                    next_arb_state = ARB_STAGE1;
                end
            end
            ARB_STAGE1: begin
                drive_level = first_lvl;
                next_arb_cnt = arb_cnt + 1'b1;
                if (arb_cnt == SETTLE_LAST) begin
                    next_arb_cnt = '0;
                    if (level_won(bus.priority_lines, first_lvl) != 3'b000) begin
                        next_arb_state = ARB_STAGE2;
                    end
                end
            end
            ARB_STAGE2: begin
                drive_level = second_lvl;
                next_arb_cnt = arb_cnt + 1'b1;
                if (arb_cnt == SETTLE_LAST) begin
                    next_arb_cnt = '0;
                    if (level_won(bus.priority_lines, second_lvl) != 3'b000) begin
                        next_arb_state = ARB_REQUEST;
                    end else begin
                        next_arb_state = ARB_STAGE1;
                    end
                end
            end
            ARB_REQUEST: begin
                if (bus.bus_grant_line) begin
                    next_arb_state = ARB_OWNED;
                end
            end
            ARB_OWNED: begin
                if (bus.bus_fault_line) begin
                    next_arb_state = ARB_IDLE;
                end
            end
            default: next_arb_state = ARB_IDLE;
        endcase
        if (ctl[`CTL_RELEASE] || bus.bus_reset) begin
            next_arb_state = ARB_IDLE;
            next_arb_cnt = '0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arb_state <= ARB_IDLE;
            arb_cnt <= '0;
        end else begin
            arb_state <= next_arb_state;
            arb_cnt <= next_arb_cnt;
        end
    end

    // ***************************************************
    // Registered pin drive
    // ***************************************************
    sysbus_out_t next_drive;

    always_comb begin
        next_drive = '0;
        next_drive.data = next_data_out;
        next_drive.data_oe = next_data_oe;
        next_drive.transfer_acknowledge_line = next_xfer_ack;
        next_drive.bus_request_line = (next_arb_state == ARB_REQUEST);
        next_drive.grant_acknowledge_line = (next_arb_state == ARB_OWNED);
        next_drive.priority_oe = drive_level;
        next_drive.busy = next_busy;
        next_drive.command_block_base_request = next_base_request;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sysbus_drive <= '0;
        end else begin
            sysbus_drive <= next_drive;
        end
    end
endmodule
`default_nettype wire

// [sim/host_port_asserts.sv]
// Purpose: Port checks for the host port
// Assumes: Host pins held at least eight cycles
// Notes: Bound to the top module
`timescale 1ns/10ps
`default_nettype none
module host_port_asserts (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awready,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [31:0] rdata,
    input wire logic system_clock,
    input wire logic local_cpu_clock,
    input wire logic baud_reference_clock,
    input wire host_port_pkg::sysbus_in_t sysbus_pins,
    input wire host_port_pkg::sysbus_out_t sysbus_drive
);
    import host_port_pkg::*;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence reset_held;
        sysbus_pins.bus_reset [*7];
    endsequence
    chk_b_holds: assert property (bvalid && !bready |=> bvalid) else $error("bvalid dropped");
    chk_b_slots: assert property (bvalid |-> !awready && !wready) else $error("slot open");
    chk_r_answer: assert property (arvalid && arready |=> rvalid) else $error("no read answer");
    chk_r_stable: assert property (rvalid && !rready |=> rvalid && $stable(rdata)) else $error("rdata moved");
    chk_ack_strobe: assert property ($rose(sysbus_drive.transfer_acknowledge_line)
        |-> $past(sysbus_pins.address_valid_strobe, 3)) else $error("ack without strobe");
    chk_status_ack: assert property (sysbus_drive.data_oe |-> sysbus_drive.transfer_acknowledge_line)
        else $error("data without ack");
    chk_grant_ack: assert property ($rose(sysbus_drive.grant_acknowledge_line)
        |-> $past(sysbus_pins.bus_grant_line, 4)) else $error("ack without grant");
    chk_owned_req: assert property (sysbus_drive.grant_acknowledge_line |-> !sysbus_drive.bus_request_line)
        else $error("request while owned");
    chk_reset_clear: assert property (reset_held |=> !sysbus_drive.busy
        && !sysbus_drive.bus_request_line && !sysbus_drive.grant_acknowledge_line) else $error("reset missed");
    chk_cpu_div: assert property ($changed(local_cpu_clock) |-> $rose(system_clock)) else $error("div");
    chk_baud_gap: assert property ($rose(baud_reference_clock) |-> ##[27:28] $rose(baud_reference_clock))
        else $error("baud gap");
endmodule
bind host_bus_slave_command_port host_port_asserts i_chk (.*);
`default_nettype wire

// [sim/host_board_model.sv]
// Purpose: Host board model on the system bus
// Assumes: Pins carried active high
// Notes: Released lines show the inverted last value
`timescale 1ns/10ps
`default_nettype none
module host_board_model (
    input wire logic aclk,
    input wire host_port_pkg::sysbus_out_t sysbus_drive,
    input wire logic [2:0] contend,
    input wire logic [7:0] grant_delay,
    output var host_port_pkg::sysbus_in_t sysbus_pins
);
    import host_port_pkg::*;
    logic [7:0] wait_cnt = 8'h00;
    initial sysbus_pins = '0;
    // ***
    // Grant and priority lines
    // ***
    always @(posedge aclk) begin
        sysbus_pins.priority_lines <= sysbus_drive.priority_oe | contend;
        wait_cnt <= sysbus_drive.bus_request_line ? wait_cnt + 8'h01 : 8'h00;
        if (sysbus_drive.bus_request_line && wait_cnt >= grant_delay)
            sysbus_pins.bus_grant_line <= 1'b1;
        else if (!sysbus_drive.bus_request_line && !sysbus_drive.grant_acknowledge_line)
            sysbus_pins.bus_grant_line <= 1'b0;
    end
    task automatic slave(input logic [23:1] a, input logic wr, input logic [15:0] d,
        output logic ack, output logic [15:0] rd);
        int n = 0;
        @(posedge aclk);
        sysbus_pins.address <= a;
        sysbus_pins.host_writes <= wr;
        sysbus_pins.data <= d;
        sysbus_pins.address_valid_strobe <= 1'b1;
        while (!sysbus_drive.transfer_acknowledge_line && n < 30) begin
            @(posedge aclk);
            n++;
        end
        ack = sysbus_drive.transfer_acknowledge_line;
        rd = sysbus_drive.data;
        sysbus_pins.address_valid_strobe <= 1'b0;
        sysbus_pins.address <= ~a;
        sysbus_pins.data <= ~d;
        repeat (10) @(posedge aclk);
    endtask
endmodule
`default_nettype wire

// [sim/testbench.sv]
// Purpose: Self-checking bench for the host port
// Assumes: Design answers per its hand-over timing
// Notes: AXI responses checked from a queue of expectations; pin results checked directly
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import host_port_pkg::*;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, ack, led_on;
    logic [7:0] awaddr = '0, araddr = '0, gdel = '0;
    logic [31:0] wdata = '0, rdata, v;
    logic [3:0] wstrb = 4'hf, bsw = 4'ha;
    logic [2:0] lvl1 = 3'h1, lvl2 = 3'h2, contend = '0;
    logic [1:0] bresp, rresp;
    logic [15:0] hd;
    logic [33:0] expq[$];
    sysbus_in_t pins;
    sysbus_out_t drv;
    int errors = 0, cmp_count = 0, cyc = 0;
    host_bus_slave_command_port i_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .sysbus_pins(pins), .board_address_switch(bsw), .first_stage_level(lvl1), .second_stage_level(lvl2),
        .sysbus_drive(drv), .led_on, .system_clock(), .local_cpu_clock(), .baud_reference_clock());
    host_board_model i_host (.aclk, .sysbus_drive(drv), .contend, .grant_delay(gdel), .sysbus_pins(pins));
    always #5 aclk = ~aclk;
    // ***
    // Checking and closing
    // ***
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("errors=%0d compares=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge aclk) begin
        if (rvalid && rready) chk({rresp, rdata}, expq.pop_front());
        if (bvalid && bready) chk({bresp, 32'h0000_0000}, expq.pop_front());
        cyc++;
        if (cyc == 20000) begin
            errors++;
            report_and_stop;
        end
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        expq.push_back({r, 32'h0000_0000});
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        expq.push_back({r, d});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic own;
        int n = 0;
        while (drv.grant_acknowledge_line !== 1'b1 && n < 400) begin
            @(posedge aclk);
            n++;
        end
    endtask
    task automatic bus_pin_pulse(input logic fault);
        if (fault) i_host.sysbus_pins.bus_fault_line <= 1'b1;
        else i_host.sysbus_pins.bus_reset <= 1'b1;
        repeat (8) @(posedge aclk);
        i_host.sysbus_pins.bus_fault_line <= 1'b0;
        i_host.sysbus_pins.bus_reset <= 1'b0;
        repeat (8) @(posedge aclk);
    endtask
    initial begin
        v = $urandom(32'hc777b5fb);
        bsw <= v[3:0];
        lvl1 <= 3'($urandom_range(1, 6));
        lvl2 <= 3'($urandom_range(1, 6));
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(8'h04, 32'h0000_0020, 2'h0);
        rd(8'h0C, 32'h0000_0000, 2'h0);
        rd(8'h10, 32'h0000_0000, 2'h2);
        wr(8'h10, 32'h0000_0001, 2'h2);
        i_host.slave({bsw, 17'h0_0000, 2'h0}, 1'b1, v[31:16], ack, hd);
        chk(34'(ack), 34'h1);
        rd(8'h04, 32'h0000_0021, 2'h0);
        rd(8'h08, {16'h0000, v[31:16]}, 2'h0);
        wr(8'h00, 32'h0000_0001, 2'h0);
        rd(8'h04, 32'h0000_0020, 2'h0);
        wr(8'h00, 32'h0000_0006, 2'h0);
        chk(34'(drv.busy), 34'h1);
        wr(8'h00, 32'h0000_0004, 2'h0);
        chk(34'(drv.busy), 34'h0);
        wr(8'h0C, v, 2'h0);
        i_host.slave({bsw, 17'h0_0000, 2'h1}, 1'b0, 16'h0000, ack, hd);
        chk(34'(hd), 34'(v[15:0]));
        i_host.slave({~bsw, 17'h0_0000, 2'h0}, 1'b1, 16'h1234, ack, hd);
        chk(34'(ack), 34'h0);
        wr(8'h00, 32'h0000_0028, 2'h0);
        chk(34'({led_on, drv.command_block_base_request}), 34'h1);
        wr(8'h00, 32'h0000_00d0, 2'h0);
        chk(34'({led_on, drv.command_block_base_request}), 34'h2);
        own;
        rd(8'h04, 32'h0000_0028, 2'h0);
        bus_pin_pulse(1'b1);
        rd(8'h04, 32'h0000_0030, 2'h0);
        contend <= 3'h7;
        gdel <= 8'h28;
        wr(8'h00, 32'h0000_0280, 2'h0);
        repeat (100) @(posedge aclk);
        rd(8'h04, 32'h0000_0120, 2'h0);
        contend <= 3'h0;
        own;
        chk(34'(drv.grant_acknowledge_line), 34'h1);
        wr(8'h00, 32'h0000_0102, 2'h0);
        rd(8'h04, 32'h0000_0022, 2'h0);
        wr(8'h00, 32'h0000_0080, 2'h0);
        i_host.slave({bsw, 17'h0_0000, 2'h0}, 1'b1, 16'h5a5a, ack, hd);
        bus_pin_pulse(1'b0);
        rd(8'h04, 32'h0000_0020, 2'h0);
        report_and_stop;
    end
endmodule
`default_nettype wire
